// >>> src/vie_pkg.sv
// Package for the VMEbus interrupt enable block
`default_nettype none
package vie_pkg;
    localparam logic [11:0] ENABLE_OFFSET = 12'h310;
    localparam logic [11:0] STATUS_OFFSET = 12'h314;
    localparam logic [11:0] MAP_LOCAL_OFFSET = 12'h318;
    localparam logic [11:0] MAP_MISC_OFFSET = 12'h31c;
    localparam logic [11:0] EVENT_OFFSET = 12'h320;
    localparam int SOFT_LVL_LSB = 25;
    localparam int MBOX_LSB = 16;
    localparam int GENERIC_BIT = 12;
    localparam int VME_BUS_ERROR_ENABLE_BIT = 10;
    localparam int PCI_BUS_ERROR_ENABLE_BIT = 9;
    localparam int DMA_BIT = 8;
    localparam int LINT_LSB = 0;
    localparam logic [31:0] ENABLE_MASK = 32'hfe0f170f | 32'h000000f0;
    localparam logic [31:0] ENABLE_RESET = 32'h00000000;
    localparam logic [31:0] MAP_LOCAL_MASK = 32'h77777777;
    localparam logic [31:0] MAP_MISC_MASK = 32'h00070777;
    localparam logic [31:0] MAP_MISC_AUTO = 32'h00020000;
    // Step after reset release at which the synchronised strap is valid
    localparam logic [1:0] STRAP_LAST = 2'h2;
    // Mailboxes have no map register in this block, so they use a fixed level
    localparam logic [2:0] MBOX_LEVEL = 3'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [6:0] softLevel;
        logic [3:0] mailbox;
        logic vmeErr;
        logic pciErr;
        logic dma;
        logic [7:0] pciLine;
    } vie_events_s;
endpackage : vie_pkg
`default_nettype wire

// >>> src/vie_sync.sv
// Two-flop synchroniser for pin inputs
`default_nettype none
module vie_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_q;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_q <= '0;
            syncOut <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end
endmodule : vie_sync
`default_nettype wire

// >>> src/vie_level_encode.sv
// Per-source level decode into a seven-line request vector
`default_nettype none
module vie_level_encode #(
    parameter int SOURCES = 22
) (
    // Source requests and their levels
    input wire logic [SOURCES-1:0] active,
    input wire logic [SOURCES*3-1:0] levels,
    // Request per VMEbus level, bit 0 is level 1
    output logic [6:0] lineReq
);
    always_comb begin
        lineReq = 7'h00;
        for (int i = 0; i < SOURCES; i++) begin
            if (active[i] && levels[i*3 +: 3] != 3'h0) begin // RULE11
                lineReq[levels[i*3 +: 3] - 3'h1] = 1'b1;
            end
        end
    end
endmodule : vie_level_encode
`default_nettype wire

// >>> src/vie_vmebus_interrupt_enable.sv
// VMEbus interrupt enable, status and level map registers on AXI4-Lite
// Summary of operation
// (RULE1) Seven level soft enables; a 0-to-1 write raises an interrupt on that level.
// (RULE2) Writing a level soft enable back to zero masks it, status kept.
// (RULE3) Generic soft enable rising asserts the soft interrupt on its mapped line.
// (RULE4) Clearing generic soft enable masks and negates its line, status kept.
// (RULE5) Generic soft enable resets to one when the auto-config option is set.
// (RULE6) Bits 19..16 enable mailboxes 3..0 toward the VMEbus.
// (RULE7) Bits 10, 9, 8 enable VMEbus error, PCI error and DMA sources.
// (RULE8) Bits 7..0 enable forwarding of local PCI interrupt inputs 7..0.
// (RULE9) Enable register is 32-bit read/write at 0x310, otherwise resets to zero.
// (RULE10) Status bits latch on event and clear on a written one.
// (RULE11) Each mapped source drives the level in its 3-bit map; zero means no line. Soft levels and mailboxes use fixed levels.
// (RULE12) Request needs status and enable both set; reserved bits read zero.
`default_nettype none
module vie_vmebus_interrupt_enable (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Power-up option strap
    input wire logic autoConfigPowerupOption,
    // Interrupt sources
    input wire logic [3:0] mailboxEvent,
    input wire logic vmeErrEvent,
    input wire logic pciErrEvent,
    input wire logic dmaEvent,
    input wire logic [7:0] pciLineIrq,
    // VMEbus requests, bit 0 is level 1, active high
    output logic [6:0] vmeIrqReq,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic [31:0] strobe_merge(logic [31:0] old, logic [31:0] data,
                                                 logic [3:0] strb, logic [31:0] mask);
        logic [31:0] m;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = strb[b] ? 8'hff : 8'h00;
        end
        return ((old & ~m) | (data & m)) & mask;
    endfunction : strobe_merge

    function automatic logic known_addr(logic [11:0] a);
        return a == vie_pkg::ENABLE_OFFSET || a == vie_pkg::STATUS_OFFSET ||
            a == vie_pkg::MAP_LOCAL_OFFSET || a == vie_pkg::MAP_MISC_OFFSET;
    endfunction : known_addr

    // Synchronised pin inputs
    logic [3:0] mboxSync;
    logic [2:0] errSync;
    logic [7:0] lineSync;
    logic autoSync;
    vie_sync #(.WIDTH(4)) u_sync_mbox (.clk(clk), .resetn(resetn), .asyncIn(mailboxEvent),
        .syncOut(mboxSync));
    vie_sync #(.WIDTH(3)) u_sync_err (.clk(clk), .resetn(resetn),
        .asyncIn({vmeErrEvent, pciErrEvent, dmaEvent}), .syncOut(errSync));
    vie_sync #(.WIDTH(9)) u_sync_line (.clk(clk), .resetn(resetn),
        .asyncIn({autoConfigPowerupOption, pciLineIrq}), .syncOut({autoSync, lineSync}));

    // Write channel capture
    logic [11:0] awAddr_q;
    logic awHave_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wHave_q;
    logic doWrite;
    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            awHave_q <= 1'b0;
            awAddr_q <= 12'h000;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !awHave_q && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (doWrite) begin
                awHave_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wHave_q <= 1'b0;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !wHave_q && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (doWrite) begin
                wHave_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= vie_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_addr(awAddr_q) ? vie_pkg::RESP_OKAY : vie_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Registers
    logic [31:0] enable_q;
    logic [31:0] enable_d;
    logic [31:0] status_q;
    logic [31:0] mapLocal_q;
    logic [31:0] mapMisc_q;
    logic [1:0] strapCnt_q;
    logic strapLoad;
    logic wrEnable;
    logic wrStatus;
    assign wrEnable = doWrite && awAddr_q == vie_pkg::ENABLE_OFFSET;
    assign wrStatus = doWrite && awAddr_q == vie_pkg::STATUS_OFFSET;
    assign enable_d = strobe_merge(enable_q, wData_q, wStrb_q, vie_pkg::ENABLE_MASK); // RULE12

    // Strap reloaded until its synchroniser, cleared by reset, holds the pin value
    assign strapLoad = strapCnt_q <= vie_pkg::STRAP_LAST;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strapCnt_q <= 2'h0;
        end else if (strapLoad) begin
            strapCnt_q <= strapCnt_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_q <= vie_pkg::ENABLE_RESET; // RULE9
        end else if (strapLoad) begin
            enable_q <= vie_pkg::ENABLE_RESET;
            enable_q[vie_pkg::GENERIC_BIT] <= autoConfigSync(autoSync); // RULE5
        end else if (wrEnable) begin
            enable_q <= enable_d; // RULE6 RULE7 RULE8 RULE2 RULE4
        end
    end

    function automatic logic autoConfigSync(logic v);
        return v;
    endfunction : autoConfigSync

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mapLocal_q <= 32'h00000000;
        end else if (doWrite && awAddr_q == vie_pkg::MAP_LOCAL_OFFSET) begin
            mapLocal_q <= strobe_merge(mapLocal_q, wData_q, wStrb_q, vie_pkg::MAP_LOCAL_MASK);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mapMisc_q <= 32'h00000000;
        end else if (strapLoad) begin
            mapMisc_q <= autoSync ? vie_pkg::MAP_MISC_AUTO : 32'h00000000;
        end else if (doWrite && awAddr_q == vie_pkg::MAP_MISC_OFFSET) begin
            mapMisc_q <= strobe_merge(mapMisc_q, wData_q, wStrb_q, vie_pkg::MAP_MISC_MASK);
        end
    end

    // Event detection
    vie_pkg::vie_events_s evt;
    logic [31:0] setVec;
    logic [31:0] clrVec;
    logic [7:0] hwPrev_q;
    logic [6:0] rise;
    logic genericRise;
    assign rise = enable_d[31:25] & ~enable_q[31:25];
    assign genericRise = wrEnable && enable_d[vie_pkg::GENERIC_BIT] &&
        !enable_q[vie_pkg::GENERIC_BIT];
    assign evt.softLevel = wrEnable ? rise : 7'h00; // RULE1
    assign evt.mailbox = mboxSync & ~hwPrev_q[7:4];
    assign evt.vmeErr = errSync[2] && !hwPrev_q[2];
    assign evt.pciErr = errSync[1] && !hwPrev_q[1];
    assign evt.dma = errSync[0] && !hwPrev_q[0];
    assign evt.pciLine = lineSync;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hwPrev_q <= 8'h00;
        end else begin
            hwPrev_q <= {mboxSync, 1'b0, errSync};
        end
    end

    always_comb begin
        setVec = 32'h00000000;
        setVec[31:25] = evt.softLevel;
        setVec[19:16] = evt.mailbox;
        setVec[vie_pkg::GENERIC_BIT] = genericRise ||
            (strapCnt_q == vie_pkg::STRAP_LAST && autoSync); // RULE3 RULE5
        setVec[vie_pkg::VME_BUS_ERROR_ENABLE_BIT] = evt.vmeErr;
        setVec[vie_pkg::PCI_BUS_ERROR_ENABLE_BIT] = evt.pciErr;
        setVec[vie_pkg::DMA_BIT] = evt.dma;
        setVec[7:0] = evt.pciLine;
        clrVec = wrStatus ? strobe_merge(32'h00000000, wData_q, wStrb_q, vie_pkg::ENABLE_MASK)
            : 32'h00000000;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= 32'h00000000;
        end else begin
            status_q <= ((status_q & ~clrVec) | setVec) & vie_pkg::ENABLE_MASK; // RULE10
        end
    end

    // Level routing
    logic [31:0] active;
    logic [6:0] lineReq;
    assign active = status_q & enable_q; // RULE12
    vie_level_encode #(.SOURCES(23)) u_encode (
        .active({active[31:25], active[19:16], active[12], active[10:8], active[7:0]}),
        .levels({3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, {4{vie_pkg::MBOX_LEVEL}},
                 mapMisc_q[18:16], mapMisc_q[10:8], mapMisc_q[6:4],
                 mapMisc_q[2:0], mapLocal_q[30:28], mapLocal_q[26:24], mapLocal_q[22:20],
                 mapLocal_q[18:16], mapLocal_q[14:12], mapLocal_q[10:8], mapLocal_q[6:4],
                 mapLocal_q[2:0]}),
        .lineReq(lineReq)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vmeIrqReq <= 7'h00;
        end else begin
            vmeIrqReq <= lineReq; // RULE11
        end
    end

    // Read channel
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= vie_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known_addr(s_axi_araddr) ? vie_pkg::RESP_OKAY
                    : vie_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    vie_pkg::ENABLE_OFFSET: s_axi_rdata <= enable_q;
                    vie_pkg::STATUS_OFFSET: s_axi_rdata <= status_q;
                    vie_pkg::MAP_LOCAL_OFFSET: s_axi_rdata <= mapLocal_q;
                    vie_pkg::MAP_MISC_OFFSET: s_axi_rdata <= mapMisc_q;
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Assertions
    soft_rise_sets_a: assert property (@(posedge clk) disable iff (!resetn) // RULE1
        (wrEnable && rise[0]) |=> status_q[25]) else $error("soft level rise not latched");
    soft_clear_keeps_a: assert property (@(posedge clk) disable iff (!resetn) // RULE2
        (wrEnable && !wrStatus && status_q[25] && !enable_d[25]) |=> status_q[25])
        else $error("soft status lost on mask");
    generic_rise_a: assert property (@(posedge clk) disable iff (!resetn) // RULE3
        genericRise |=> status_q[vie_pkg::GENERIC_BIT]) else $error("generic soft not set");
    generic_mask_a: assert property (@(posedge clk) disable iff (!resetn) // RULE4
        (status_q[vie_pkg::GENERIC_BIT] && !enable_q[vie_pkg::GENERIC_BIT] &&
         (active & ~(32'h1 << vie_pkg::GENERIC_BIT)) == 32'h00000000) |=> vmeIrqReq == 7'h00)
        else $error("generic soft not masked");
    strap_reset_a: assert property (@(posedge clk) disable iff (!resetn) // RULE5
        (strapCnt_q == vie_pkg::STRAP_LAST) |=> enable_q[vie_pkg::GENERIC_BIT] == $past(autoSync))
        else $error("strap not applied");
    reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RULE12
        ((enable_q | status_q) & ~vie_pkg::ENABLE_MASK) == 32'h00000000)
        else $error("reserved bit set");
    status_w1c_a: assert property (@(posedge clk) disable iff (!resetn) // RULE10
        (wrStatus && clrVec[0] && !setVec[0]) |=> !status_q[0]) else $error("w1c failed");
    irq_follow_a: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        (active[7] && mapLocal_q[30:28] == 3'h1) |=> vmeIrqReq[0])
        else $error("line not raised");
    map_zero_a: assert property (@(posedge clk) disable iff (!resetn) // RULE11
        (lineReq == 7'h00) |=> vmeIrqReq == 7'h00) else $error("spurious request");
    enable_write_a: assert property (@(posedge clk) disable iff (!resetn) // RULE9
        wrEnable && !strapLoad |=> enable_q == $past(enable_d)) else $error("enable write");
    cover_write_c: cover property (@(posedge clk) disable iff (!resetn) wrEnable);
    cover_read_c: cover property (@(posedge clk) disable iff (!resetn)
        s_axi_rvalid && s_axi_rready);
    cover_irq_c: cover property (@(posedge clk) disable iff (!resetn) vmeIrqReq != 7'h00);
endmodule : vie_vmebus_interrupt_enable
`default_nettype wire

// >>> dv/vie_irq_handler.sv
// Far-end VMEbus interrupt handler model: tracks the highest requested level
`default_nettype none
module vie_irq_handler (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Requests from the bridge, bit 0 is level 1
    input wire logic [6:0] vmeIrqReq,
    // Level the handler would acknowledge next, 0 when idle
    output logic [2:0] ackLevel
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ackLevel <= 3'h0;
        end else begin
            ackLevel <= 3'h0;
            for (int i = 0; i < 7; i++) begin
                if (vmeIrqReq[i]) begin
                    ackLevel <= 3'(i + 1);
                end
            end
        end
    end
endmodule : vie_irq_handler
`default_nettype wire

// >>> dv/vie_vmebus_interrupt_enable_tb.sv
// Testbench for the VMEbus interrupt enable block
`default_nettype none
module vie_vmebus_interrupt_enable_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] EN = vie_pkg::ENABLE_OFFSET;
    localparam logic [11:0] ST = vie_pkg::STATUS_OFFSET;
    localparam logic [11:0] ML = vie_pkg::MAP_LOCAL_OFFSET;
    localparam logic [11:0] MM = vie_pkg::MAP_MISC_OFFSET;
    logic clk, resetn, autoCfg, bready, rready, awvalid, wvalid, arvalid;
    logic [3:0] mbox, wstrb;
    logic [2:0] srcEv, ackLevel;
    logic [7:0] pciLine;
    logic [6:0] vmeIrqReq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    int miscompares, cmp_count;
    vie_vmebus_interrupt_enable vie_vmebus_interrupt_enable_inst (
        .clk(clk), .resetn(resetn), .autoConfigPowerupOption(autoCfg),
        .mailboxEvent(mbox), .vmeErrEvent(srcEv[2]), .pciErrEvent(srcEv[1]),
        .dmaEvent(srcEv[0]), .pciLineIrq(pciLine), .vmeIrqReq(vmeIrqReq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    vie_irq_handler vie_irq_handler_inst (
        .clk(clk), .resetn(resetn), .vmeIrqReq(vmeIrqReq), .ackLevel(ackLevel)
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic doReset(input logic strap);
        autoCfg <= strap;
        resetn <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : doReset
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d);
        bit awDone, wDone;
        awDone = 0;
        wDone = 0;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awDone && wDone && bvalid) break;
            if (!awDone && awready) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        check({30'h0, bresp}, {30'h0, vie_pkg::RESP_OKAY}, "write response");
    endtask : axiWrite
    task automatic readChk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] resp);
        bit arDone;
        arDone = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arDone && rvalid) break;
            if (!arDone && arready) begin
                arDone = 1;
                arvalid <= 1'b0;
            end
        end
        check(rdata, exp, "read data");
        check({30'h0, rresp}, {30'h0, resp}, "read response");
    endtask : readChk
    task automatic expectReq(input logic [6:0] exp);
        int n;
        n = 0;
        if (exp == 7'h0) repeat (8) @(posedge clk);
        while (vmeIrqReq !== exp && n < 20) begin
            @(posedge clk);
            n++;
        end
        check({25'h0, vmeIrqReq}, {25'h0, exp}, "request lines");
    endtask : expectReq
    task automatic clearStatus();
        axiWrite(ST, 32'hffffffff);
    endtask : clearStatus
    localparam logic [1:0] OK = vie_pkg::RESP_OKAY;
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end
    initial begin
        {resetn, autoCfg, bready, rready, awvalid, wvalid, arvalid} = '0;
        {mbox, wstrb, srcEv, pciLine, awaddr, araddr, wdata} = '0;
        miscompares = 0;
        cmp_count = 0;
        doReset(1'b0);
        readChk(EN, 32'h0, OK);
        readChk(12'h400, 32'h0, vie_pkg::RESP_SLVERR);
        axiWrite(EN, 32'hffffffff);
        readChk(EN, vie_pkg::ENABLE_MASK, OK);
        axiWrite(EN, 32'h0);
        clearStatus();
        $display("test registers done");
        for (int n = 1; n <= 7; n++) begin
            axiWrite(EN, 32'h1 << (vie_pkg::SOFT_LVL_LSB + n - 1));
            expectReq(7'h1 << (n - 1));
            @(posedge clk);
            check({29'h0, ackLevel}, 32'(n), "handler level");
            axiWrite(EN, 32'h0);
            expectReq(7'h0);
            readChk(ST, 32'h1 << (vie_pkg::SOFT_LVL_LSB + n - 1), OK);
            clearStatus();
            readChk(ST, 32'h0, OK);
        end
        $display("test level soft done");
        axiWrite(MM, 32'h00060000);
        axiWrite(EN, 32'h1 << vie_pkg::GENERIC_BIT);
        expectReq(7'h20);
        axiWrite(EN, 32'h0);
        expectReq(7'h0);
        readChk(ST, 32'h1 << vie_pkg::GENERIC_BIT, OK);
        clearStatus();
        $display("test generic soft done");
        axiWrite(MM, 32'h00000123);
        axiWrite(EN, 32'h00000700);
        for (int i = 0; i < 3; i++) begin
            srcEv <= 3'b100 >> i;
            repeat (4) @(posedge clk);
            srcEv <= 3'b000;
            expectReq(7'h1 << i);
            clearStatus();
            expectReq(7'h0);
        end
        $display("test error sources done");
        for (int k = 0; k < 8; k++) begin
            axiWrite(ML, 32'((k % 7) + 1) << (4 * k));
            axiWrite(EN, 32'h1 << k);
            pciLine <= 8'h1 << k;
            expectReq(7'h1 << (k % 7));
            pciLine <= 8'h00;
            repeat (3) @(posedge clk);
            clearStatus();
            expectReq(7'h0);
        end
        axiWrite(ML, 32'h0);
        axiWrite(EN, 32'h000000ff);
        pciLine <= 8'h01;
        expectReq(7'h0);
        axiWrite(ML, 32'h1);
        axiWrite(EN, 32'h0);
        expectReq(7'h0);
        readChk(ST, 32'h1, OK);
        pciLine <= 8'h00;
        repeat (3) @(posedge clk);
        clearStatus();
        $display("test local lines done");
        axiWrite(EN, 32'h000f0000);
        readChk(EN, 32'h000f0000, OK);
        mbox <= 4'hf;
        repeat (4) @(posedge clk);
        mbox <= 4'h0;
        repeat (4) @(posedge clk);
        readChk(ST, 32'h000f0000, OK);
        expectReq(7'h1 << (vie_pkg::MBOX_LEVEL - 3'h1));
        clearStatus();
        expectReq(7'h0);
        $display("test mailboxes done");
        doReset(1'b1);
        readChk(EN, 32'h1 << vie_pkg::GENERIC_BIT, OK);
        readChk(MM, vie_pkg::MAP_MISC_AUTO, OK);
        expectReq(7'h02);
        $display("test power-up option done");
        conclude();
    end
endmodule : vie_vmebus_interrupt_enable_tb
`default_nettype wire
